/* rtl/scid_pkg.sv */
/*
  constants for the smart-card cause, card-detect and transmit status block.
  assumes an 8-bit special-function bus with 16-bit addresses.
*/
package scid_pkg;
  localparam logic [15:0] CAUSE_ADDR      = 16'hFE01;
  localparam logic [15:0] DETECT_ADDR     = 16'hFE05;
  localparam logic [15:0] TX_ADDR         = 16'hFE06;
  localparam logic [7:0]  CAUSE_RESET     = 8'h00;
  localparam logic [7:0]  DETECT_RESET    = 8'h00;
  localparam logic [7:0]  TX_RESET        = 8'h00;
  // card_irq_cause fields
  localparam int CAUSE_WAIT    = 7;
  localparam int CAUSE_CARD    = 6;
  localparam int CAUSE_SUPPLY  = 5;
  localparam int CAUSE_RXAV    = 4;
  localparam int CAUSE_TXEVT   = 3;
  localparam int CAUSE_TXDONE  = 2;
  localparam int CAUSE_TX_ERROR_FLAG   = 1;
  localparam int CAUSE_RX_ERROR_FLAG   = 0;
  // card_detect_ctrl fields
  localparam int DET_DEBOUNCE  = 7;
  localparam int DET_ENABLE    = 6;
  localparam int DET_POLARITY  = 3;
  localparam int DET_PULLUP_N  = 2;
  localparam int DET_PULLDOWN  = 1;
  localparam int DET_PRESENT   = 0;
  // tx_ctrl_status fields
  localparam int TX_DIRECT_IO  = 7;
  localparam int TX_FULL       = 5;
  localparam int TX_EMPTY      = 4;
  localparam int TX_UNDERRUN   = 3;
  localparam int TX_LAST       = 2;
  localparam int TX_RX_SEL     = 1;
  localparam int TX_BREAK      = 0;
  localparam logic [7:0] DETECT_WR_MASK = 8'hCE;
  localparam logic [7:0] TX_WR_MASK     = 8'h86;
  // debounce: stable time in ms counted on a tick of given rate
  localparam int DEBOUNCE_MS    = 64;
  localparam int TICK_HZ        = 1000;
  localparam int DEBOUNCE_TICKS = (DEBOUNCE_MS * TICK_HZ) / 1000;
  localparam int DEB_W          = 7;
endpackage : scid_pkg

/* rtl/scid_debounce.sv */
/*
  card-detect debounce: qualifies a detect level on a slow tick.
  assumes level is already synchronised and tick is a one-cycle pulse on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module scid_debounce
  import scid_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic tick,
  input  wire logic bypass,
  input  wire logic level,
  output logic      present
);
  logic [DEB_W-1:0] cnt_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q   <= '0;
      present <= 1'b0;
    end else if (!level) begin
      cnt_q   <= '0;
      present <= 1'b0;
    end else if (bypass) begin
      present <= 1'b1;
    end else if (!present && tick) begin
      if (cnt_q == DEB_W'(DEBOUNCE_TICKS - 1)) begin
        present <= 1'b1;
      end else begin
        cnt_q <= cnt_q + DEB_W'(1);
      end
    end
  end
endmodule // scid_debounce
`default_nettype wire

/* rtl/scid_regs.sv */
/*
  smart-card interrupt cause, card-detect and transmit control/status registers.
  assumes fifos, length counter, supply timer, receive status and enable register
  live elsewhere on ref_clk; pins and card clock arrive asynchronously.
*/
// What this block does
// - reading the cause register clears its clear-on-read cause bits.
// - sync mode: set wait-timeout when length counter reaches its loaded value.
// - set card-event on insertion, removal or interface fault, even powered down.
// - set supply-timer cause on timer expiry; cause read clears it.
// - receive-available follows receive fifo not empty; no clear on read.
// - bypass mode: raise receive-available on each falling card io edge.
// - set transmit-event when fifo empty or full sets; tx status read clears.
// - set transmit-done per sent byte or check byte, not on T=0 break.
// - set transmit-error on break or underrun; tx status read clears.
// - set receive-error on overrun or parity; receive status read clears.
// - each cause bit is gated by its own enable bit.
// - interface select picks which io line feeds the bypass receive-available edge; other causes ignore it.
// - debounce needs 64 ms stable detect; removal clears immediately.
// - power-down skips debounce but presence still tracks the pin.
// - polarity 1 means high is present, 0 means low is present.
// - card-present is read-only; any change is a card event.
// - drive pull-up enable (low active) and pull-down enable from bits.
// - sync direct-io with count at max or zero drives io from control bit.
// - transmit-full stays set while the transmit fifo is full.
// - with last-byte set, hold transmit-empty until final byte is sent.
// - set underrun when fifo empties after a byte without last-byte set.
// - set break-detected when card signals parity error; read clears.
`timescale 1ns/1ps
`default_nettype none
module scid_regs
  import scid_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // special-function bus
  input  wire logic [15:0] sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic [7:0]       sfr_rdata,
  // pins, asynchronous
  input  wire logic        card_detect_pin,
  input  wire logic        card_clk,
  input  wire logic        card_io_in,
  input  wire logic        ext_card_io_in,
  output logic             card_io_out,
  output logic             card_io_oe,
  output logic             pullup_en_n,
  output logic             pulldown_en,
  // neighbouring units, same clock
  input  wire logic        kbd_tick_1khz,
  input  wire logic        power_down,
  input  wire logic        interface_select,
  input  wire logic        sync_mode,
  input  wire logic        bypass_mode,
  input  wire logic        t1_mode,
  input  wire logic [7:0]  irq_enable,
  input  wire logic [7:0]  length_count,
  input  wire logic [7:0]  length_max,
  input  wire logic        io_ctrl_data,
  input  wire logic        io_ctrl_dir,
  input  wire logic        fifo_tx_bit,
  input  wire logic        fifo_tx_oe,
  input  wire logic        interface_fault,
  input  wire logic        supply_timer_expired,
  input  wire logic        rx_fifo_not_empty,
  input  wire logic        tx_fifo_full_raw,
  input  wire logic        tx_fifo_empty_raw,
  input  wire logic        byte_sent,
  input  wire logic        check_byte_sent,
  input  wire logic        break_seen,
  input  wire logic        rx_overrun,
  input  wire logic        rx_parity_err,
  input  wire logic        rx_status_read,
  output logic             direct_io_mode,
  output logic             last_tx_byte,
  output logic             tx_rx_select,
  output logic             tx_fifo_empty,
  output logic             tx_fifo_full,
  output logic             card_present,
  output logic             card_irq
);
  // two-flop synchronisers for pins
  logic [1:0] det_sync_q;
  logic [1:0] clk_sync_q;
  logic [1:0] io_sync_q;
  logic [1:0] eio_sync_q;
  logic       clk_prev_q;
  logic       io_prev_q;
  logic       eio_prev_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      det_sync_q <= 2'h0;
      clk_sync_q <= 2'h0;
      io_sync_q  <= 2'h3;
      eio_sync_q <= 2'h3;
      clk_prev_q <= 1'b0;
      io_prev_q  <= 1'b1;
      eio_prev_q <= 1'b1;
    end else begin
      det_sync_q <= {det_sync_q[0], card_detect_pin};
      clk_sync_q <= {clk_sync_q[0], card_clk};
      io_sync_q  <= {io_sync_q[0], card_io_in};
      eio_sync_q <= {eio_sync_q[0], ext_card_io_in};
      clk_prev_q <= clk_sync_q[1];
      io_prev_q  <= io_sync_q[1];
      eio_prev_q <= eio_sync_q[1];
    end
  end

  logic clk_fall;
  logic io_fall;
  assign clk_fall = clk_prev_q & ~clk_sync_q[1];
  // only the selected interface's io line is watched
  assign io_fall  = interface_select ? (eio_prev_q & ~eio_sync_q[1])
                                     : (io_prev_q & ~io_sync_q[1]);

  // bus decode
  logic rd_cause;
  logic rd_detect;
  logic rd_tx;
  logic wr_detect;
  logic wr_tx;
  assign rd_cause  = sfr_rd & (sfr_addr == CAUSE_ADDR);
  assign rd_detect = sfr_rd & (sfr_addr == DETECT_ADDR);
  assign rd_tx     = sfr_rd & (sfr_addr == TX_ADDR);
  assign wr_detect = sfr_wr & (sfr_addr == DETECT_ADDR);
  assign wr_tx     = sfr_wr & (sfr_addr == TX_ADDR);

  // card detect control
  logic [7:0] det_ctrl_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      det_ctrl_q <= DETECT_RESET;
    end else if (wr_detect) begin
      det_ctrl_q <= sfr_wdata & DETECT_WR_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pullup_en_n <= 1'b1;
      pulldown_en <= 1'b0;
    end else begin
      pullup_en_n <= det_ctrl_q[DET_PULLUP_N];
      pulldown_en <= det_ctrl_q[DET_PULLDOWN];
    end
  end

  logic det_level;
  logic present_raw;
  // polarity bit set: high level means card in
  assign det_level = det_ctrl_q[DET_ENABLE]
                   & ~(det_sync_q[1] ^ det_ctrl_q[DET_POLARITY]);

  scid_debounce u_debounce (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tick    (kbd_tick_1khz),
    .bypass  (power_down | ~det_ctrl_q[DET_DEBOUNCE]),
    .level   (det_level),
    .present (present_raw)
  );

  logic card_change;
  assign card_change = present_raw ^ card_present;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      card_present <= 1'b0;
    end else begin
      card_present <= present_raw;
    end
  end

  // transmit control and status
  logic [7:0] tx_ctrl_q;
  logic       final_done_q;
  logic       underrun_q;
  logic       break_q;
  logic       empty_set;
  logic       full_set;
  logic       empty_d;
  logic       underrun_evt;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ctrl_q <= TX_RESET;
    end else if (wr_tx) begin
      tx_ctrl_q <= sfr_wdata & TX_WR_MASK;
    end
  end

  // last byte done: check byte in T=1, last word with empty fifo in T=0
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      final_done_q <= 1'b0;
    end else if (!tx_fifo_empty_raw || !tx_ctrl_q[TX_LAST]) begin
      final_done_q <= 1'b0;
    end else if (t1_mode ? check_byte_sent : (byte_sent & ~break_seen)) begin
      final_done_q <= 1'b1;
    end
  end

  assign empty_d = tx_fifo_empty_raw & (~tx_ctrl_q[TX_LAST] | final_done_q);
  assign empty_set = empty_d & ~tx_fifo_empty;
  assign full_set  = tx_fifo_full_raw & ~tx_fifo_full;
  assign underrun_evt = byte_sent & tx_fifo_empty_raw & ~tx_ctrl_q[TX_LAST];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_fifo_empty <= 1'b0;
      tx_fifo_full  <= 1'b0;
    end else begin
      tx_fifo_empty <= empty_d;
      tx_fifo_full  <= tx_fifo_full_raw;
    end
  end

  // sticky status, set wins over read clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      underrun_q <= 1'b0;
      break_q    <= 1'b0;
    end else begin
      underrun_q <= underrun_evt | (underrun_q & ~rd_tx);
      break_q    <= break_seen | (break_q & ~rd_tx);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      direct_io_mode <= 1'b0;
      last_tx_byte   <= 1'b0;
      tx_rx_select   <= 1'b0;
    end else begin
      direct_io_mode <= tx_ctrl_q[TX_DIRECT_IO];
      last_tx_byte   <= tx_ctrl_q[TX_LAST];
      tx_rx_select   <= tx_ctrl_q[TX_RX_SEL];
    end
  end

  // card io source select
  logic direct_sel;
  assign direct_sel = sync_mode & tx_ctrl_q[TX_DIRECT_IO]
                    & ((length_count == length_max) | (length_count == 8'h00));
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      card_io_out <= 1'b1;
      card_io_oe  <= 1'b0;
    end else begin
      card_io_out <= direct_sel ? io_ctrl_data : fifo_tx_bit;
      card_io_oe  <= direct_sel ? io_ctrl_dir : fifo_tx_oe;
    end
  end

  // length counter moves a cycle after the synchronised falling edge; check then
  logic clk_fall_q;
  logic wait_evt;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_fall_q <= 1'b0;
    end else begin
      clk_fall_q <= clk_fall;
    end
  end
  assign wait_evt = sync_mode & clk_fall_q & (length_max != 8'h00)
                  & (length_count == length_max);

  // cause register
  logic [7:0] cause_q;
  logic       bypass_av_q;
  logic       rx_av;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bypass_av_q <= 1'b0;
    end else if (!bypass_mode) begin
      bypass_av_q <= 1'b0;
    end else begin
      bypass_av_q <= io_fall | (bypass_av_q & ~rd_cause);
    end
  end
  assign rx_av = bypass_mode ? bypass_av_q : rx_fifo_not_empty;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_q <= CAUSE_RESET;
    end else begin
      cause_q[CAUSE_WAIT]   <= wait_evt | (cause_q[CAUSE_WAIT] & ~rd_cause);
      cause_q[CAUSE_CARD]   <= card_change | interface_fault
                             | (cause_q[CAUSE_CARD] & ~rd_cause);
      cause_q[CAUSE_SUPPLY] <= supply_timer_expired
                             | (cause_q[CAUSE_SUPPLY] & ~rd_cause);
      cause_q[CAUSE_RXAV]   <= rx_av;
      cause_q[CAUSE_TXEVT]  <= empty_set | full_set
                             | (cause_q[CAUSE_TXEVT] & ~rd_tx);
      cause_q[CAUSE_TXDONE] <= ((byte_sent & ~(~t1_mode & break_seen)) | check_byte_sent)
                             | (cause_q[CAUSE_TXDONE] & ~rd_cause);
      cause_q[CAUSE_TX_ERROR_FLAG]  <= underrun_evt | break_seen
                             | (cause_q[CAUSE_TX_ERROR_FLAG] & ~rd_tx);
      cause_q[CAUSE_RX_ERROR_FLAG]  <= rx_overrun | rx_parity_err
                             | (cause_q[CAUSE_RX_ERROR_FLAG] & ~rx_status_read);
    end
  end

  // single request line; enable register is outside
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      card_irq <= 1'b0;
    end else begin
      card_irq <= |(cause_q & irq_enable);
    end
  end

  // read data, registered; unmapped reads return zero
  logic [7:0] rd_d;
  always_comb begin
    rd_d = 8'h00;
    if (rd_cause) begin
      rd_d = cause_q;
    end else if (rd_detect) begin
      rd_d = det_ctrl_q;
      rd_d[DET_PRESENT] = card_present;
    end else if (rd_tx) begin
      rd_d = tx_ctrl_q;
      rd_d[TX_FULL]     = tx_fifo_full;
      rd_d[TX_EMPTY]    = tx_fifo_empty;
      rd_d[TX_UNDERRUN] = underrun_q;
      rd_d[TX_BREAK]    = break_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= rd_d;
    end
  end
endmodule // scid_regs
`default_nettype wire

/* testbench/scid_card_model.sv */
/*
  behavioural card on the io line, plus a gated card clock.
  assumes the io line has a pull-up, so a released line reads high.
*/
`timescale 1ns/1ps
`default_nettype none
module scid_card_model (
  input  wire logic io_out,
  input  wire logic io_oe,
  input  wire logic pull_low,
  input  wire logic run,
  output logic      io_in,
  output logic      clk
);
  // released line floats to the pull-up level, never the last value
  assign io_in = io_oe ? io_out : !pull_low;
  initial clk = 1'b0;
  // clock stands low outside frames
  always begin
    #62.5;
    clk = run ? ~clk : 1'b0;
  end
endmodule // scid_card_model
`default_nettype wire

/* testbench/scid_regs_chk.sv */
/*
  port-level checks of the cause, detect and transmit registers.
  assumes one clock domain, ref_clk, with async active-low rst_n.
*/
`timescale 1ns/1ps
`default_nettype none
module scid_regs_chk
  import scid_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [15:0] sfr_addr,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic [7:0]  irq_enable,
  input wire logic        card_irq,
  input wire logic        rx_fifo_not_empty,
  input wire logic        bypass_mode,
  input wire logic        supply_timer_expired,
  input wire logic        byte_sent,
  input wire logic        check_byte_sent,
  input wire logic        tx_fifo_empty_raw,
  input wire logic        last_tx_byte,
  input wire logic        rx_overrun,
  input wire logic        tx_fifo_full_raw,
  input wire logic        tx_fifo_full,
  input wire logic        pullup_en_n,
  input wire logic        pulldown_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic rdc   = sfr_rd && sfr_addr == CAUSE_ADDR;
  wire logic quiet = !(supply_timer_expired || byte_sent || check_byte_sent);
  property p_masked;
    irq_enable == 8'h00 |=> !card_irq;
  endproperty
  a_masked: assert property (p_masked) else $error("irq with all enables off");
  property p_rxav;
    (rx_fifo_not_empty && !bypass_mode) [*3] ##0 rdc |=> sfr_rdata[CAUSE_RXAV];
  endproperty
  a_rxav: assert property (p_rxav) else $error("rx available lost");
  // two reads with no supply or transmit events between must find supply and transmit-done at zero
  property p_cor;
    (rdc && quiet) ##1 quiet ##1 (rdc && quiet) |=> !sfr_rdata[CAUSE_SUPPLY] && !sfr_rdata[CAUSE_TXDONE];
  endproperty
  a_cor: assert property (p_cor) else $error("cause not cleared by read");
  property p_supply;
    (supply_timer_expired && irq_enable[CAUSE_SUPPLY]) ##1 irq_enable[CAUSE_SUPPLY] |=> card_irq;
  endproperty
  a_supply: assert property (p_supply) else $error("supply expiry gave no irq");
  property p_rx_error_flag;
    (rx_overrun && irq_enable[CAUSE_RX_ERROR_FLAG]) ##1 irq_enable[CAUSE_RX_ERROR_FLAG] |=> card_irq;
  endproperty
  a_rx_error_flag: assert property (p_rx_error_flag) else $error("overrun gave no irq");
  property p_undr;
    (byte_sent && tx_fifo_empty_raw && !last_tx_byte && irq_enable[CAUSE_TX_ERROR_FLAG]) ##1 irq_enable[CAUSE_TX_ERROR_FLAG]
    |=> card_irq;
  endproperty
  a_undr: assert property (p_undr) else $error("underrun gave no irq");
  property p_full;
    (tx_fifo_full_raw [*2] |-> tx_fifo_full) and (!tx_fifo_full_raw [*2] |-> !tx_fifo_full);
  endproperty
  a_full: assert property (p_full) else $error("full flag not tracking fifo");
  property p_pull;
    (sfr_wr && sfr_addr == DETECT_ADDR) ##1 !sfr_wr
    |=> pullup_en_n == $past(sfr_wdata[DET_PULLUP_N], 2) && pulldown_en == $past(sfr_wdata[DET_PULLDOWN], 2);
  endproperty
  a_pull: assert property (p_pull) else $error("pull enables not from bits");
  c_irq: cover property (card_irq);
  c_full: cover property (tx_fifo_full);
  c_txrd: cover property (sfr_rd && sfr_addr == TX_ADDR);
endmodule // scid_regs_chk
bind scid_regs scid_regs_chk u_chk (.ref_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
  .irq_enable, .card_irq, .rx_fifo_not_empty, .bypass_mode, .supply_timer_expired, .byte_sent,
  .check_byte_sent, .tx_fifo_empty_raw, .last_tx_byte, .rx_overrun, .tx_fifo_full_raw, .tx_fifo_full,
  .pullup_en_n, .pulldown_en);
`default_nettype wire

/* testbench/smart_card_irq_detect_tx_status_tb_top.sv */
/*
  self-checking bench for scid_regs with a card model on the io line.
  assumes a random tick, so the 64-tick debounce takes about 128 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module smart_card_irq_detect_tx_status_tb_top;
  import scid_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] sfr_addr = 16'h0000;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic        rd_seen = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  irq_enable = 8'h00;
  logic [7:0]  length_count = 8'h00;
  logic [7:0]  length_max = 8'h00;
  logic [7:0]  ev = 8'h00;
  logic [15:0] seed = 16'hA5FC;
  logic [7:0]  exp_q[$];
  logic        card_detect_pin = 1'b0, power_down = 1'b0, sync_mode = 1'b0, bypass_mode = 1'b0;
  logic        rx_fifo_not_empty = 1'b0, tx_fifo_full_raw = 1'b0, tx_fifo_empty_raw = 1'b0;
  logic        pull_low = 1'b0, run = 1'b0, fifo_tx_bit = 1'b0, io_ctrl_data = 1'b0, ext_card_io_in = 1'b1;
  // random tick stands in for the slow keypad tick, far faster than 1 kHz
  logic        kbd_tick_1khz = 1'b1, fifo_tx_oe = 1'b0, io_ctrl_dir = 1'b0, interface_select = 1'b0;
  logic        t1_mode = 1'b0;
  int          err_total = 0;
  int          num_checks = 0;
  wire logic [7:0] sfr_rdata;
  wire logic   card_clk, card_io_in, card_io_out, card_io_oe, pullup_en_n, pulldown_en, direct_io_mode;
  wire logic   last_tx_byte, tx_rx_select, tx_fifo_empty, tx_fifo_full, card_present, card_irq;
  wire logic   supply_timer_expired = ev[0];
  wire logic   byte_sent = ev[1];
  wire logic   break_seen = ev[2];
  wire logic   rx_overrun = ev[3];
  wire logic   rx_status_read = ev[4];
  wire logic   interface_fault = ev[5];
  wire logic   check_byte_sent = ev[6];
  wire logic   rx_parity_err = ev[7];
  scid_regs uut (.ref_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .card_detect_pin,
    .card_clk, .card_io_in, .ext_card_io_in, .card_io_out, .card_io_oe, .pullup_en_n, .pulldown_en,
    .kbd_tick_1khz, .power_down, .interface_select, .sync_mode, .bypass_mode, .t1_mode, .irq_enable,
    .length_count, .length_max, .io_ctrl_data, .io_ctrl_dir, .fifo_tx_bit, .fifo_tx_oe, .interface_fault,
    .supply_timer_expired, .rx_fifo_not_empty, .tx_fifo_full_raw, .tx_fifo_empty_raw, .byte_sent,
    .check_byte_sent, .break_seen, .rx_overrun, .rx_parity_err, .rx_status_read, .direct_io_mode,
    .last_tx_byte, .tx_rx_select, .tx_fifo_empty, .tx_fifo_full, .card_present, .card_irq);
  scid_card_model card (.io_out(card_io_out), .io_oe(card_io_oe), .pull_low, .run, .io_in(card_io_in),
    .clk(card_clk));
  always #4 ref_clk = ~ref_clk;
  function automatic logic [15:0] xs(input logic [15:0] s);
    logic [15:0] t;
    t = s ^ (s << 7);
    t = t ^ (t >> 9);
    return t ^ (t << 8);
  endfunction
  always @(posedge ref_clk) begin
    seed <= xs(seed);
    fifo_tx_bit <= seed[0];
    io_ctrl_data <= seed[1];
    ext_card_io_in <= interface_select ? !pull_low : seed[2];
    kbd_tick_1khz <= seed[3];
  end
  task automatic finish_test();
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // read data stands one cycle after the taking edge
  always @(posedge ref_clk) begin
    rd_seen <= sfr_rd;
    if (rd_seen)
      chk("rdata", sfr_rdata, exp_q.pop_front());
  end
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    exp_q.push_back(e);
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= 8'h00;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // bounded wait; a miss is counted and ends the run
  task automatic wait_present(input logic v, input int n);
    int k;
    k = 0;
    while (card_present !== v && k < n) begin
      @(posedge ref_clk);
      k++;
    end
    chk("present", {7'h00, card_present}, {7'h00, v});
    if (card_present !== v)
      finish_test();
  endtask
  // io source: control bits when sel, serializer otherwise
  task automatic io_chk(input logic sel);
    logic [7:0] e;
    wt(2);
    e = sel ? {6'h00, io_ctrl_data, io_ctrl_dir} : {6'h00, fifo_tx_bit, fifo_tx_oe};
    wt(1);
    chk("io", {6'h00, card_io_out, card_io_oe}, e);
  endtask
  initial begin
    logic [7:0] en;
    wt(3);
    rst_n <= 1'b1;
    rd(CAUSE_ADDR, CAUSE_RESET);
    rd(DETECT_ADDR, DETECT_RESET);
    rd(TX_ADDR, TX_RESET);
    wr(DETECT_ADDR, 8'h8E);
    wr(DETECT_ADDR, 8'hCE);
    card_detect_pin <= 1'b1;
    wt(70);
    chk("early", {7'h00, card_present}, 8'h00);
    wait_present(1'b1, 300);
    rd(DETECT_ADDR, 8'hCF);
    rd(CAUSE_ADDR, 8'h40);
    card_detect_pin <= 1'b0;
    wait_present(1'b0, 8);
    rd(CAUSE_ADDR, 8'h40);
    power_down <= 1'b1;
    wr(DETECT_ADDR, 8'hC4);
    wait_present(1'b1, 8);
    chk("pulls", {6'h00, pullup_en_n, pulldown_en}, 8'h02);
    rd(CAUSE_ADDR, 8'h40);
    power_down <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      en = {seed[7:6], i[0], seed[4:0]} & 8'hE7;
      irq_enable <= en;
      pulse(8'h01);
      wt(2);
      chk("irq", {7'h00, card_irq}, {7'h00, en[CAUSE_SUPPLY]});
      rd(CAUSE_ADDR, 8'h20);
      rd(CAUSE_ADDR, 8'h00);
    end
    irq_enable <= 8'h11;
    rx_fifo_not_empty <= 1'b1;
    rd(CAUSE_ADDR, 8'h10);
    rd(CAUSE_ADDR, 8'h10);
    rx_fifo_not_empty <= 1'b0;
    wt(3);
    rd(CAUSE_ADDR, 8'h00);
    pulse(8'h88);
    rd(CAUSE_ADDR, 8'h01);
    pulse(8'h10);
    rd(CAUSE_ADDR, 8'h00);
    bypass_mode <= 1'b1;
    wt(4);
    pull_low <= 1'b1;
    wt(6);
    pull_low <= 1'b0;
    wt(4);
    rd(CAUSE_ADDR, 8'h10);
    rd(CAUSE_ADDR, 8'h00);
    bypass_mode <= 1'b0;
    sync_mode <= 1'b1;
    length_count <= 8'h05;
    length_max <= 8'h05;
    run <= 1'b1;
    wt(40);
    run <= 1'b0;
    sync_mode <= 1'b0;
    wt(4);
    rd(CAUSE_ADDR, 8'h80);
    irq_enable <= 8'h0E;
    wr(TX_ADDR, 8'h02);
    tx_fifo_full_raw <= 1'b1;
    wt(3);
    rd(CAUSE_ADDR, 8'h08);
    rd(TX_ADDR, 8'h22);
    tx_fifo_full_raw <= 1'b0;
    tx_fifo_empty_raw <= 1'b1;
    wt(3);
    rd(TX_ADDR, 8'h12);
    rd(CAUSE_ADDR, 8'h00);
    pulse(8'h02);
    rd(CAUSE_ADDR, 8'h06);
    rd(TX_ADDR, 8'h1A);
    rd(CAUSE_ADDR, 8'h00);
    rd(TX_ADDR, 8'h12);
    tx_fifo_empty_raw <= 1'b0;
    pulse(8'h06);
    rd(CAUSE_ADDR, 8'h02);
    rd(TX_ADDR, 8'h03);
    rd(CAUSE_ADDR, 8'h00);
    pulse(8'h60);
    rd(CAUSE_ADDR, 8'h44);
    t1_mode <= 1'b1;
    wr(TX_ADDR, 8'h86);
    tx_fifo_empty_raw <= 1'b1;
    wt(3);
    chk("ctl", {direct_io_mode, 4'h0, last_tx_byte, tx_rx_select, tx_fifo_empty}, 8'h86);
    pulse(8'h02);
    pulse(8'h40);
    rd(CAUSE_ADDR, 8'h0C);
    rd(TX_ADDR, 8'h96);
    sync_mode <= 1'b1;
    io_ctrl_dir <= 1'b1;
    io_chk(1'b1);
    length_count <= 8'h03;
    io_chk(1'b0);
    length_count <= 8'h00;
    io_chk(1'b1);
    interface_select <= 1'b1;
    wt(4);
    bypass_mode <= 1'b1;
    wt(16);
    rd(CAUSE_ADDR, 8'h00);
    pull_low <= 1'b1;
    wt(6);
    rd(CAUSE_ADDR, 8'h10);
    wt(3);
    finish_test();
  end
endmodule // smart_card_irq_detect_tx_status_tb_top
`default_nettype wire
